// *** hw/lgs_pkg.sv ***
package lgs_pkg;

	// Configuration offsets (byte addresses)
	localparam logic [7:0] HINTS_OFF = 8'h3C; // Dword holding hints in upper half
	localparam logic [7:0] HINTS_BYTE = 8'h3E;
	localparam logic [7:0] ENDIAN_OFF = 8'h40;
	localparam logic [7:0] CAPHDR_OFF = 8'h44;

	// Hint defaults when no EEPROM answers
	localparam logic [7:0] ACCESS_INTERVAL_DFLT = 8'h04;
	localparam logic [7:0] BURST_DURATION_DFLT = 8'h02;

	// Field positions
	localparam int HINT_INTERVAL_LSB = 8;
	localparam int SWAP_BIT = 0;

	// Capability header contents
	localparam logic [7:0] CAP_KIND_PM = 8'h01;
	localparam logic [7:0] CAP_NEXT_NONE = 8'h00;

	// Reset value of the endian control register
	localparam logic [31:0] ENDIAN_RST = 32'h0000_0000;

	// Read data register value after reset and for unmapped offsets
	localparam logic [31:0] RDATA_RST = 32'h0000_0000;

endpackage

// *** hw/lgs_swap.sv ***
`timescale 1ns/1ps
module lgs_swap
(
	// Control
	input wire logic swap_i,
	// Data
	input wire logic [31:0] data_i,
	output logic [31:0] data_o
);

	// Byte-reverse a quadlet when big-endian is selected
	always_comb
	begin
		if (swap_i)
			data_o = {data_i[7:0], data_i[15:8], data_i[23:16], data_i[31:24]};
		else
			data_o = data_i;
	end

endmodule

// *** hw/lgs_regs.sv ***
`timescale 1ns/1ps
// How it works
// - EEPROM present: load hints after global reset
// - No EEPROM: hints default to four and two
// - Upper hint byte read-only, EEPROM updatable
// - Lower hint byte read-only, EEPROM updatable
// - Swap bit byte-reverses every PCI quadlet
// - Endian register upper bits read zero
// - Capability next pointer reads zero
// - Capability kind code reads power management
module lgs_regs
(
	// Clock and global reset
	input wire logic clk_i,
	input wire logic rst_b_i,
	// Configuration access, dword aligned
	input wire logic [7:0] cfg_addr_i,
	input wire logic cfg_wr_i,
	input wire logic [3:0] cfg_be_i,
	input wire logic [31:0] cfg_wdata_i,
	output logic [31:0] cfg_rdata_o,
	// EEPROM loader result
	input wire logic eeprom_present_i,
	input wire logic eeprom_load_i,
	input wire logic [15:0] eeprom_hints_i,
	// PCI data path
	input wire logic [31:0] pci_in_i,
	output logic [31:0] pci_in_o,
	input wire logic [31:0] core_out_i,
	output logic [31:0] core_out_o,
	output logic swap_o
);

	////////////////////////////////////////////////////////////////
	logic [15:0] hints_r;
	logic [15:0] hints_nxt;
	logic swap_r;
	logic swap_nxt;
	logic [31:0] rdata_r;
	logic [31:0] rdata_nxt;
	logic loaded_r;
	logic loaded_nxt;
	logic load_take;
	logic endian_wr;

	// Offset compare, shared by both decoders and the checks
	function automatic logic at_offset(input logic [7:0] addr, input logic [7:0] off);
		at_offset = (addr == off);
	endfunction

	// Load taken once per reset; a late loader pulse cannot overwrite
	assign load_take = eeprom_present_i && eeprom_load_i && !loaded_r;
	// Only byte lane 0 carries a writable bit
	assign endian_wr = cfg_wr_i && at_offset(cfg_addr_i, lgs_pkg::ENDIAN_OFF) && cfg_be_i[0];

	////////////////////////////////////////////////////////////////
	// Hint next state; software writes never reach it
	always_comb
	begin
		hints_nxt = hints_r;
		loaded_nxt = loaded_r;
		if (load_take)
		begin
			hints_nxt = eeprom_hints_i;
			loaded_nxt = 1'b1;
		end
	end

	// Hint registers; defaults stand until the loader answers
	always_ff @(posedge clk_i)
	begin
		if (!rst_b_i)
		begin
			hints_r <= {lgs_pkg::ACCESS_INTERVAL_DFLT, lgs_pkg::BURST_DURATION_DFLT};
			loaded_r <= 1'b0;
		end
		else
		begin
			hints_r <= hints_nxt;
			loaded_r <= loaded_nxt;
		end
	end

	////////////////////////////////////////////////////////////////
	// Swap bit next state; upper write bits are dropped
	always_comb
	begin
		swap_nxt = swap_r;
		if (endian_wr)
			swap_nxt = cfg_wdata_i[lgs_pkg::SWAP_BIT];
	end

	// Swap register; cleared so traffic after reset is little-endian
	always_ff @(posedge clk_i)
	begin
		if (!rst_b_i)
			swap_r <= lgs_pkg::ENDIAN_RST[lgs_pkg::SWAP_BIT];
		else
			swap_r <= swap_nxt;
	end

	////////////////////////////////////////////////////////////////
	// Read decode; unmapped offsets read zero
	always_comb
	begin
		rdata_nxt = lgs_pkg::RDATA_RST;
		if (at_offset(cfg_addr_i, lgs_pkg::HINTS_OFF))
			rdata_nxt = {hints_r, 16'h0000};
		else if (at_offset(cfg_addr_i, lgs_pkg::ENDIAN_OFF))
			rdata_nxt = {31'h0, swap_r};
		else if (at_offset(cfg_addr_i, lgs_pkg::CAPHDR_OFF))
			rdata_nxt = {16'h0000, lgs_pkg::CAP_NEXT_NONE, lgs_pkg::CAP_KIND_PM};
	end

	// Read data register; one cycle of latency eases host bus timing
	always_ff @(posedge clk_i)
	begin
		if (!rst_b_i)
			rdata_r <= lgs_pkg::RDATA_RST;
		else
			rdata_r <= rdata_nxt;
	end

	// Outputs straight from flops
	assign cfg_rdata_o = rdata_r;
	assign swap_o = swap_r;

	////////////////////////////////////////////////////////////////
	// Swap applies to both directions of quadlet traffic
	lgs_swap u_swap_in
	(
		.swap_i(swap_r),
		.data_i(pci_in_i),
		.data_o(pci_in_o)
	);

	lgs_swap u_swap_out
	(
		.swap_i(swap_r),
		.data_i(core_out_i),
		.data_o(core_out_o)
	);

	////////////////////////////////////////////////////////////////
	// Checks sample on the rising edge; all but a_swap_reset and a_hint_default rest while reset is low
	// Write of the endian register as the decoder sees it
	sequence s_endian_wr;
		cfg_wr_i && cfg_addr_i == lgs_pkg::ENDIAN_OFF && cfg_be_i[0];
	endsequence

	a_swap_write: assert property (@(posedge clk_i) disable iff (!rst_b_i)
		s_endian_wr |=> swap_o == $past(cfg_wdata_i[0]))
		else $error("swap bit did not take written value");

	a_swap_reset: assert property (@(posedge clk_i)
		!rst_b_i |=> !swap_o)
		else $error("swap bit not cleared by reset");

	a_swap_data: assert property (@(posedge clk_i) disable iff (!rst_b_i)
		swap_o |-> pci_in_o[31:24] == pci_in_i[7:0] && core_out_o[7:0] == core_out_i[31:24])
		else $error("quadlet not swapped");

	a_noswap_data: assert property (@(posedge clk_i) disable iff (!rst_b_i)
		!swap_o |-> pci_in_o == pci_in_i && core_out_o == core_out_i)
		else $error("quadlet altered without swap");

	a_endian_upper: assert property (@(posedge clk_i) disable iff (!rst_b_i)
		$past(cfg_addr_i) == lgs_pkg::ENDIAN_OFF |-> cfg_rdata_o[31:1] == 31'h0000_0000)
		else $error("endian upper bits not zero");

	a_cap_header: assert property (@(posedge clk_i) disable iff (!rst_b_i)
		cfg_addr_i == lgs_pkg::CAPHDR_OFF |=> cfg_rdata_o == 32'h0000_0001)
		else $error("capability header wrong");

	a_hint_default: assert property (@(posedge clk_i)
		!rst_b_i ##1 (!eeprom_present_i || !eeprom_load_i) |-> hints_r == 16'h0402)
		else $error("hint defaults wrong");

	a_hint_load: assert property (@(posedge clk_i) disable iff (!rst_b_i)
		eeprom_present_i && eeprom_load_i && !loaded_r |=> hints_r == $past(eeprom_hints_i))
		else $error("EEPROM hints not loaded");

	a_hint_ro: assert property (@(posedge clk_i) disable iff (!rst_b_i)
		!(eeprom_present_i && eeprom_load_i && !loaded_r) |=> $stable(hints_r))
		else $error("hints changed without load");

	a_hint_read: assert property (@(posedge clk_i) disable iff (!rst_b_i)
		cfg_addr_i == lgs_pkg::HINTS_OFF && !eeprom_load_i |=> cfg_rdata_o[31:16] == hints_r)
		else $error("hint readback wrong");

	////////////////////////////////////////////////////////////////
	// Refusals: loads after the first and writes that must not land
	sequence s_reload;
		eeprom_load_i && loaded_r;
	endsequence

	a_hint_once: assert property (@(posedge clk_i) disable iff (!rst_b_i)
		s_reload |=> $stable(hints_r))
		else $error("second EEPROM load changed hints");

	a_hint_nowrite: assert property (@(posedge clk_i) disable iff (!rst_b_i)
		cfg_wr_i && at_offset(cfg_addr_i, lgs_pkg::HINTS_OFF) && !load_take |=> $stable(hints_r))
		else $error("software write changed hints");

	a_other_wr: assert property (@(posedge clk_i) disable iff (!rst_b_i)
		cfg_wr_i && !at_offset(cfg_addr_i, lgs_pkg::ENDIAN_OFF) |=> $stable(swap_o))
		else $error("write elsewhere moved swap bit");

	a_endian_mask: assert property (@(posedge clk_i) disable iff (!rst_b_i)
		cfg_wr_i && at_offset(cfg_addr_i, lgs_pkg::ENDIAN_OFF) && !cfg_be_i[0] |=> $stable(swap_o))
		else $error("masked lane moved swap bit");

	a_swap_hold: assert property (@(posedge clk_i) disable iff (!rst_b_i)
		!endian_wr |=> $stable(swap_o))
		else $error("swap bit moved without write");

	// Full byte order, both directions, not only the end bytes
	a_swap_full: assert property (@(posedge clk_i) disable iff (!rst_b_i)
		swap_o |-> pci_in_o == {pci_in_i[7:0], pci_in_i[15:8], pci_in_i[23:16], pci_in_i[31:24]}
		&& core_out_o == {core_out_i[7:0], core_out_i[15:8], core_out_i[23:16], core_out_i[31:24]})
		else $error("quadlet byte order wrong");

endmodule

// *** verification/lgs_eeprom_model.sv ***
`timescale 1ns/1ps
module lgs_eeprom_model
(
	// Clock and test control
	input wire logic clk_i,
	input wire logic fit_i,
	input wire logic go_i,
	input wire logic [15:0] val_i,
	// Loader result
	output logic eeprom_present_o,
	output logic eeprom_load_o,
	output logic [15:0] eeprom_hints_o
);
	// One-cycle load pulse
	always_ff @(posedge clk_i)
	begin
		eeprom_load_o <= go_i;
	end
	// Off the pulse the hints invert, so stale data never looks valid
	assign eeprom_present_o = fit_i;
	assign eeprom_hints_o = eeprom_load_o ? val_i : ~val_i;
endmodule

// *** verification/lgs_regs_tb_top.sv ***
`timescale 1ns/1ps
module lgs_regs_tb_top;
	logic clk_i, rst_b_i, cfg_wr_i, swap_o, eeprom_present_i, eeprom_load_i, fit, go;
	logic [7:0] cfg_addr_i;
	logic [3:0] cfg_be_i;
	logic [31:0] cfg_wdata_i, cfg_rdata_o, pci_in_i, pci_in_o, core_out_i, core_out_o;
	logic [15:0] eeprom_hints_i, val;
	int fails = 0;
	int checked = 0;
	typedef struct {logic [7:0] a; logic [3:0] b; logic [31:0] d; logic [31:0] e;} lgs_row_s;
	// Writes then read-back; writes to read-only, masked or unmapped places must not stick
	lgs_row_s rows [6] = '{'{8'h44, 4'hF, 32'hFFFF_FFFF, 32'h1}, '{8'h40, 4'hE, 32'hFFFF_FFFF, 32'h0},
		'{8'h40, 4'hF, 32'hFFFF_FFFF, 32'h1}, '{8'h3C, 4'hF, 32'hFFFF_FFFF, 32'h0402_0000},
		'{8'h40, 4'hF, 32'h0000_0001, 32'h1}, '{8'h48, 4'hF, 32'hFFFF_FFFF, 32'h0}};
	lgs_regs DUT (.clk_i, .rst_b_i, .cfg_addr_i, .cfg_wr_i, .cfg_be_i, .cfg_wdata_i, .cfg_rdata_o,
		.eeprom_present_i, .eeprom_load_i, .eeprom_hints_i, .pci_in_i, .pci_in_o, .core_out_i, .core_out_o, .swap_o);
	lgs_eeprom_model PM (.clk_i, .fit_i(fit), .go_i(go), .val_i(val), .eeprom_present_o(eeprom_present_i),
		.eeprom_load_o(eeprom_load_i), .eeprom_hints_o(eeprom_hints_i));
	// 250 MHz clock
	initial
	begin
		clk_i = 1'b0;
		forever #2 clk_i = ~clk_i;
	end
	task automatic chk(input string n, input logic [31:0] e, input logic [31:0] s);
		checked++;
		if (s !== e)
		begin
			fails++;
			$display("CHECK FAILED %s exp %h got %h", n, e, s);
		end
	endtask
	// Write strobe lasts one cycle, then the same address is read back
	task automatic acc(input logic [7:0] a, input logic w, input logic [3:0] b, input logic [31:0] d);
		@(negedge clk_i);
		cfg_addr_i = a;
		cfg_wr_i = w;
		cfg_be_i = b;
		cfg_wdata_i = d;
		@(negedge clk_i);
		cfg_wr_i = 1'b0;
		@(posedge clk_i);
		#1;
	endtask
	task automatic pth(input logic s);
		@(negedge clk_i);
		pci_in_i = 32'h1122_3344;
		core_out_i = 32'hA1B2_C3D4;
		#1;
		chk("pci_in", s ? 32'h4433_2211 : 32'h1122_3344, pci_in_o);
		chk("core_out", s ? 32'hD4C3_B2A1 : 32'hA1B2_C3D4, core_out_o);
		chk("swap", {31'h0, s}, {31'h0, swap_o});
	endtask
	task automatic rst(input logic f);
		@(negedge clk_i);
		rst_b_i = 1'b0;
		fit = f;
		repeat (20) @(negedge clk_i);
		rst_b_i = 1'b1;
	endtask
	// Loader pulse, then read the hint dword
	task automatic ld(input logic [15:0] v, input logic [31:0] e);
		@(negedge clk_i);
		go = 1'b1;
		val = v;
		@(negedge clk_i);
		go = 1'b0;
		acc(8'h3C, 1'b0, 4'h0, 32'h0);
		chk("hints", e, cfg_rdata_o);
	endtask
	task automatic summarize();
		$display("checked %0d fails %0d", checked, fails);
		if (fails == 0 && checked > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	// Main sequence
	initial
	begin
		{rst_b_i, cfg_wr_i, go, fit, cfg_addr_i, cfg_be_i, cfg_wdata_i, pci_in_i, core_out_i, val} = '0;
		rst(1'b0);
		pth(1'b0);
		acc(8'h3C, 1'b0, 4'h0, 32'h0);
		chk("hint_dflt", 32'h0402_0000, cfg_rdata_o);
		foreach (rows[i])
		begin
			acc(rows[i].a, 1'b1, rows[i].b, rows[i].d);
			chk("row", rows[i].e, cfg_rdata_o);
		end
		pth(1'b1);
		$display("table test done");
		ld(16'hA55A, 32'h0402_0000);
		rst(1'b1);
		pth(1'b0);
		ld(16'hA55A, 32'hA55A_0000);
		ld(16'h1234, 32'hA55A_0000);
		$display("reset and load test done");
		summarize();
	end
endmodule
